// [hdl/cdr_defines.vh]
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CDR_SEL_ADDR   8'h00
`define CDR_MODE_ADDR  8'h01
`define CDR_BUF_BASE   8'h10
`define CDR_NUM_BUF    3'h6
`define CDR_OFS_CON    3'h0
`define CDR_OFS_SIDH   3'h1
`define CDR_OFS_SIDL   3'h2
`define CDR_OFS_EIDH   3'h3
`define CDR_OFS_EIDL   3'h4

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CDR_MODE_LEGACY  2'h0
`define CDR_SEL_RESET    8'h00
`define CDR_MODE_RESET   2'h0
`define CDR_BIT_FLAG7    7
`define CDR_BIT_ACCALL   6
`define CDR_BIT_TX_REQUEST_BIT    3
`define CDR_BIT_AUTO_REMOTE_REPLY_ENABLE    2
`define CDR_SEL_LSB      2
`define CDR_SIDL_TX_MASK 8'heb
`define CDR_SIDL_EXT     3

`endif

// [hdl/cdr_msg_buffers.v]
`timescale 1ns/100ps
`include "cdr_defines.vh"

// ----------------------------------------
// Register map and handshakes
// ----------------------------------------
// 0x00  direction select, bits 7:2
//       Buffer 5 down to buffer 0
//       1 transmit, 0 receive
//       Bits 1:0 read zero
// 0x01  operating mode, bits 1:0
//       0 legacy: buffers idle, read zero
//       1 to 3: buffers active
// 0x10 + 8n  buffer n control
// 0x11 + 8n  identifier high byte
// 0x12 + 8n  identifier low byte
// 0x13 + 8n  extended byte, bits 15:8
// 0x14 + 8n  extended byte, bits 7:0
// Offsets 5 to 7 of a buffer read zero

// Receive control byte
//   Bit 7    full, set by a stored frame
//   Bit 6    accept everything
//   Bit 5    stored frame was a remote request
//   Bits 4:0 index of the admitting filter

// Transmit control byte
//   Bit 7    done, set by a good frame
//   Bit 6    aborted
//   Bit 5    arbitration lost
//   Bit 4    bus error
//   Bit 3    request; writing 0 aborts
//   Bit 2    auto reply to remote requests
//   Bits 1:0 sending order, 3 highest

// Receive low identifier byte
//   Bits 7:5 standard 2:0 or extended 20:18
//   Bit 4    substitute remote bit, extended only
//   Bit 3    extended frame
//   Bit 2    zero
//   Bits 1:0 extended 17:16
// Transmit low identifier byte
//   Same, with bits 4 and 2 held at zero

// Receive side
//   One frame per rx_frame pulse
//   Lowest free accepting receive buffer wins
//   Frame dropped when none is free
//   Hazard: a full buffer is never
//   overwritten, so software that is
//   slow to clear it loses frames

// Transmit side
//   Offer registered one cycle after
//   a request; engine takes it with
//   tx_start while tx_pending_q is high
//   Offer frozen until an end pulse
//   Arbitration loss and bus error
//   keep the request for a retry
//   Abort on the bus waits for
//   tx_abort_ack; idle abort is at once
//   Limitation: tx_start while no
//   offer stands is ignored

module cdr_msg_buffers (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_q,
   input  wire        rx_frame,
   input  wire        rx_valid,
   input  wire        rx_filter_pass,
   input  wire [4:0]  rx_filter_idx,
   input  wire [28:0] rx_ident,
   input  wire        rx_ext,
   input  wire        rx_rtr,
   input  wire        rx_srr,
   output reg         tx_pending_q,
   output reg  [2:0]  tx_buf_q,
   output reg  [28:0] tx_ident_q,
   output reg         tx_ext_q,
   output reg         tx_abort_q,
   input  wire        tx_start,
   input  wire        tx_ok,
   input  wire        tx_arb_lost,
   input  wire        tx_bus_err,
   input  wire        tx_abort_ack
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [5:0] dir_q;
   reg  [1:0] mode_q;
   reg  [5:0] flag7_q;
   reg  [5:0] accall_q;
   reg  [5:0] rtr_ro_q;
   reg  [5:0] abt_q;
   reg  [5:0] larb_q;
   reg  [5:0] err_q;
   reg  [5:0] req_q;
   reg  [5:0] auto_remote_reply_enable_q;
   reg  [5:0] abreq_q;
   reg  [4:0] filhit_q [0:5];
   reg  [1:0] pri_q    [0:5];
   reg  [7:0] sidh_q   [0:5];
   reg  [7:0] sidl_q   [0:5];
   reg  [7:0] eidh_q   [0:5];
   reg  [7:0] eidl_q   [0:5];
   reg        busy_q;
   reg  [2:0] cur_q;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire       active   = (mode_q != `CDR_MODE_LEGACY);
   wire [7:0] boff     = reg_addr - `CDR_BUF_BASE;
   wire [2:0] bidx     = boff[5:3];
   wire [2:0] breg     = boff[2:0];
   wire       in_buf   = (reg_addr >= `CDR_BUF_BASE) && (boff[7:6] == 2'h0) &&
                         (bidx < `CDR_NUM_BUF) && (breg <= `CDR_OFS_EIDL);
   wire       buf_wr   = reg_wr && in_buf && active;

   // Identifier of a buffer as it goes on the bus
   function [28:0] buf_ident;
      input [7:0] sh;
      input [7:0] sl;
      input [7:0] eh;
      input [7:0] el;
      begin
         if (sl[`CDR_SIDL_EXT]) begin
            buf_ident = {sh, sl[7:5], sl[1:0], eh, el};
         end else begin
            buf_ident = {18'h00000, sh, sl[7:5]};
         end
      end
   endfunction

   // ----------------------------------------
   // Receive routing, auto reply and transmit arbitration
   // ----------------------------------------
   reg  [5:0]  rx_pick;
   reg  [5:0]  rtr_hit;
   reg  [5:0]  lock;
   reg         rx_taken;
   reg         any_pend;
   reg  [2:0]  best;
   reg  [1:0]  best_pri;
   reg  [28:0] rx_id_norm;
   integer     k;

   // Lowest free receive buffer that accepts the frame (accept everything or filter pass) takes it; full ones are skipped
   always @* begin
      rx_pick    = 6'h00;
      rtr_hit    = 6'h00;
      lock       = 6'h00;
      rx_taken   = 1'b0;
      any_pend   = 1'b0;
      best       = 3'h0;
      best_pri   = 2'h0;
      rx_id_norm = rx_ext ? rx_ident : {18'h00000, rx_ident[10:0]};
      for (k = 0; k < 6; k = k + 1) begin
         lock[k] = req_q[k] | (busy_q && (cur_q == k[2:0]));
         if (active && rx_frame && !dir_q[k] && !flag7_q[k] && !rx_taken &&
             (accall_q[k] || (rx_valid && rx_filter_pass))) begin
            rx_pick[k] = 1'b1;
            rx_taken   = 1'b1;
         end
         if (active && rx_frame && rx_valid && rx_rtr && dir_q[k] && auto_remote_reply_enable_q[k] &&
             !lock[k] && (sidl_q[k][`CDR_SIDL_EXT] == rx_ext) &&
             (buf_ident(sidh_q[k], sidl_q[k], eidh_q[k], eidl_q[k]) == rx_id_norm)) begin
            rtr_hit[k] = 1'b1;
         end
         // Later index wins a tie, so order is fixed and repeatable
         if (active && dir_q[k] && req_q[k] && !abreq_q[k] &&
             (!any_pend || (pri_q[k] >= best_pri))) begin
            any_pend = 1'b1;
            best     = k[2:0];
            best_pri = pri_q[k];
         end
      end
   end

   // ----------------------------------------
   // Global registers and transmit hand-off
   // ----------------------------------------
   // Direction is not frozen: software must keep a buffer on the bus in transmit
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dir_q        <= 6'h00;
         mode_q       <= `CDR_MODE_RESET;
         busy_q       <= 1'b0;
         cur_q        <= 3'h0;
         tx_pending_q <= 1'b0;
         tx_buf_q     <= 3'h0;
         tx_ident_q   <= 29'h00000000;
         tx_ext_q     <= 1'b0;
         tx_abort_q   <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == `CDR_SEL_ADDR)) begin
            dir_q <= reg_wdata[7:`CDR_SEL_LSB];
         end
         if (reg_wr && (reg_addr == `CDR_MODE_ADDR)) begin
            mode_q <= reg_wdata[1:0];
         end
         if (busy_q) begin
            tx_abort_q <= abreq_q[cur_q];
            if (tx_ok || tx_arb_lost || tx_bus_err || tx_abort_ack) begin
               busy_q       <= 1'b0;
               tx_abort_q   <= 1'b0;
               tx_pending_q <= 1'b0;
            end
         end else if (tx_start && tx_pending_q) begin
            busy_q <= 1'b1;
            cur_q  <= tx_buf_q;
         end else begin
            tx_pending_q <= any_pend;
            tx_buf_q     <= best;
            tx_ident_q   <= buf_ident(sidh_q[best], sidl_q[best],
                                      eidh_q[best], eidl_q[best]);
            tx_ext_q     <= sidl_q[best][`CDR_SIDL_EXT];
         end
      end
   end

   // ----------------------------------------
   // Per-buffer registers
   // ----------------------------------------
   // Software writes first, hardware events after, so a hardware event always beats a software write
   integer i;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flag7_q  <= 6'h00;
         accall_q <= 6'h00;
         rtr_ro_q <= 6'h00;
         abt_q    <= 6'h00;
         larb_q   <= 6'h00;
         err_q    <= 6'h00;
         req_q    <= 6'h00;
         auto_remote_reply_enable_q  <= 6'h00;
         abreq_q  <= 6'h00;
         for (i = 0; i < 6; i = i + 1) begin
            filhit_q[i] <= 5'h00;
            pri_q[i]    <= 2'h0;
            sidh_q[i]   <= 8'h00;
            sidl_q[i]   <= 8'h00;
            eidh_q[i]   <= 8'h00;
            eidl_q[i]   <= 8'h00;
         end
      end else begin
         for (i = 0; i < 6; i = i + 1) begin
            // Software side
            if (buf_wr && (bidx == i[2:0])) begin
               if (!dir_q[i]) begin
                  if (breg == `CDR_OFS_CON) begin
                     flag7_q[i]  <= reg_wdata[`CDR_BIT_FLAG7];
                     accall_q[i] <= reg_wdata[`CDR_BIT_ACCALL];
                  end
               end else if (!lock[i]) begin
                  case (breg)
                     `CDR_OFS_CON: begin
                        pri_q[i]   <= reg_wdata[1:0];
                        auto_remote_reply_enable_q[i] <= reg_wdata[`CDR_BIT_AUTO_REMOTE_REPLY_ENABLE];
                        req_q[i]   <= reg_wdata[`CDR_BIT_TX_REQUEST_BIT];
                        flag7_q[i] <= reg_wdata[`CDR_BIT_FLAG7];
                        if (reg_wdata[`CDR_BIT_TX_REQUEST_BIT]) begin
                           flag7_q[i] <= 1'b0;
                           abt_q[i]   <= 1'b0;
                           larb_q[i]  <= 1'b0;
                           err_q[i]   <= 1'b0;
                        end
                     end
                     `CDR_OFS_SIDH: sidh_q[i] <= reg_wdata;
                     `CDR_OFS_SIDL: sidl_q[i] <= reg_wdata & `CDR_SIDL_TX_MASK;
                     `CDR_OFS_EIDH: eidh_q[i] <= reg_wdata;
                     `CDR_OFS_EIDL: eidl_q[i] <= reg_wdata;
                     default: ;
                  endcase
               end else if ((breg == `CDR_OFS_CON) && req_q[i] &&
                            !reg_wdata[`CDR_BIT_TX_REQUEST_BIT]) begin
                  // Idle buffer aborts at once; one on the bus waits for the engine
                  if (busy_q && (cur_q == i[2:0])) begin
                     abreq_q[i] <= 1'b1;
                  end else begin
                     req_q[i] <= 1'b0;
                     abt_q[i] <= 1'b1;
                  end
               end
            end
            // Receive store
            if (rx_pick[i]) begin
               flag7_q[i]  <= 1'b1;
               rtr_ro_q[i] <= rx_rtr;
               filhit_q[i] <= rx_filter_idx;
               sidh_q[i]   <= rx_ext ? rx_ident[28:21] : rx_ident[10:3];
               sidl_q[i]   <= {(rx_ext ? rx_ident[20:18] : rx_ident[2:0]),
                               rx_ext & rx_srr, rx_ext, 1'b0,
                               (rx_ext ? rx_ident[17:16] : 2'h0)};
               eidh_q[i]   <= rx_ext ? rx_ident[15:8] : 8'h00;
               eidl_q[i]   <= rx_ext ? rx_ident[7:0] : 8'h00;
            end
            // Auto reply to a remote request
            if (rtr_hit[i]) begin
               req_q[i]   <= 1'b1;
               flag7_q[i] <= 1'b0;
               abt_q[i]   <= 1'b0;
               larb_q[i]  <= 1'b0;
               err_q[i]   <= 1'b0;
            end
            // Outcome of the frame on the bus
            if (busy_q && (cur_q == i[2:0])) begin
               if (tx_ok) begin
                  req_q[i]   <= 1'b0;
                  flag7_q[i] <= 1'b1;
                  abreq_q[i] <= 1'b0;
               end else if (tx_abort_ack) begin
                  req_q[i]   <= 1'b0;
                  abt_q[i]   <= 1'b1;
                  abreq_q[i] <= 1'b0;
               end else begin
                  if (tx_arb_lost) begin
                     larb_q[i] <= 1'b1;
                  end
                  if (tx_bus_err) begin
                     err_q[i] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   // Buffer registers read zero in legacy mode, unmapped addresses read zero
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_q <= 8'h00;
         if (reg_addr == `CDR_SEL_ADDR) begin
            reg_rdata_q <= {dir_q, 2'h0};
         end else if (reg_addr == `CDR_MODE_ADDR) begin
            reg_rdata_q <= {6'h00, mode_q};
         end else if (in_buf && active) begin
            case (breg)
               `CDR_OFS_CON: begin
                  if (dir_q[bidx]) begin
                     reg_rdata_q <= {flag7_q[bidx], abt_q[bidx], larb_q[bidx], err_q[bidx],
                                     req_q[bidx], auto_remote_reply_enable_q[bidx], pri_q[bidx]};
                  end else begin
                     reg_rdata_q <= {flag7_q[bidx], accall_q[bidx], rtr_ro_q[bidx],
                                     filhit_q[bidx]};
                  end
               end
               `CDR_OFS_SIDH: reg_rdata_q <= sidh_q[bidx];
               `CDR_OFS_SIDL: reg_rdata_q <= dir_q[bidx] ?
                                             (sidl_q[bidx] & `CDR_SIDL_TX_MASK) :
                                             sidl_q[bidx];
               `CDR_OFS_EIDH: reg_rdata_q <= eidh_q[bidx];
               `CDR_OFS_EIDL: reg_rdata_q <= eidl_q[bidx];
               default:       reg_rdata_q <= 8'h00;
            endcase
         end
      end
   end

endmodule

// [testbench/cdr_engine_model.sv]
`timescale 1ns/100ps
module cdr_engine_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       tx_pending_q,
   input  wire logic       tx_abort_q,
   input  wire logic [1:0] outcome,
   input  wire logic [3:0] lag,
   output logic            tx_start,
   output logic            tx_ok,
   output logic            tx_arb_lost,
   output logic            tx_bus_err,
   output logic            tx_abort_ack
);
   // ----------------------------------------
   // Frame engine: idle, wait, on bus, cool-down
   // ----------------------------------------
   logic [1:0] st_q;
   logic [3:0] cnt_q;

   // Cool-down state lets the offer fall before the next look
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_q <= 2'h0;
         cnt_q <= 4'h0;
         {tx_start, tx_ok, tx_arb_lost, tx_bus_err, tx_abort_ack} <= 5'h00;
      end else begin
         {tx_start, tx_ok, tx_arb_lost, tx_bus_err, tx_abort_ack} <= 5'h00;
         cnt_q <= cnt_q + 4'h1;
         case (st_q)
            2'h0: if (tx_pending_q) begin
               st_q  <= 2'h1;
               cnt_q <= 4'h0;
            end
            2'h1: if (!tx_pending_q) begin
               st_q <= 2'h0;
            end else if (cnt_q >= lag) begin
               tx_start <= 1'b1;
               st_q     <= 2'h2;
               cnt_q    <= 4'h0;
            end
            2'h2: if (tx_abort_q || cnt_q >= lag) begin
               tx_ok        <= !tx_abort_q && outcome == 2'h0;
               tx_arb_lost  <= !tx_abort_q && outcome == 2'h1;
               tx_bus_err   <= !tx_abort_q && outcome == 2'h2;
               tx_abort_ack <= tx_abort_q || outcome == 2'h3;
               st_q         <= 2'h3;
            end
            default: st_q <= 2'h0;
         endcase
      end
   end
endmodule

// [testbench/cdr_msg_buffers_assertions.sv]
`timescale 1ns/100ps
module cdr_msg_buffers_assertions (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata_q,
   input wire logic        tx_pending_q,
   input wire logic [2:0]  tx_buf_q,
   input wire logic [28:0] tx_ident_q,
   input wire logic        tx_ext_q,
   input wire logic        tx_abort_q,
   input wire logic        tx_start,
   input wire logic        tx_ok,
   input wire logic        tx_arb_lost,
   input wire logic        tx_bus_err,
   input wire logic        tx_abort_ack
);
   // ----------------------------------------
   // Mode mirror and on-bus tracker
   // ----------------------------------------
   logic [1:0] mode_q;
   logic       busy_q;
   wire        end_pulse = tx_ok | tx_arb_lost | tx_bus_err | tx_abort_ack;

   // Only a start taken while offered counts; end pulses never overlap a start
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode_q <= 2'h0;
         busy_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 8'h01)
            mode_q <= reg_wdata[1:0];
         if (end_pulse)
            busy_q <= 1'b0;
         else if (tx_start && tx_pending_q)
            busy_q <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_legacy_read;
      reg_rd && reg_addr >= 8'h10 && mode_q == 2'h0;
   endsequence
   sequence s_attempt_end;
      busy_q && end_pulse;
   endsequence

   a_legacy_reads_zero: assert property (s_legacy_read |=> reg_rdata_q == 8'h00)
      else $error("buffer register visible in legacy mode");
   a_legacy_no_offer: assert property (mode_q == 2'h0 |-> !tx_pending_q)
      else $error("offer made in legacy mode");
   a_sel_low_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata_q[1:0] == 2'h0)
      else $error("select register low bits not zero");
   a_sidl_bit2_zero: assert property (reg_rd && reg_addr[2:0] == 3'h2 |=> !reg_rdata_q[2])
      else $error("identifier low byte bit 2 not zero");
   a_offer_frozen: assert property (busy_q && !end_pulse |=> $stable(tx_buf_q) && $stable(tx_ident_q) && $stable(tx_ext_q))
      else $error("offer changed during attempt");
   a_end_drops_offer: assert property (s_attempt_end |=> !tx_pending_q && !tx_abort_q)
      else $error("offer kept after attempt ended");
   a_abort_on_bus: assert property (tx_abort_q |-> busy_q)
      else $error("abort raised with nothing on bus");
   a_abort_holds: assert property (tx_abort_q && !end_pulse |=> tx_abort_q)
      else $error("abort dropped before attempt ended");
endmodule

bind cdr_msg_buffers cdr_msg_buffers_assertions i_chk (
   .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tx_pending_q(tx_pending_q),
   .tx_buf_q(tx_buf_q), .tx_ident_q(tx_ident_q), .tx_ext_q(tx_ext_q), .tx_abort_q(tx_abort_q),
   .tx_start(tx_start), .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost), .tx_bus_err(tx_bus_err),
   .tx_abort_ack(tx_abort_ack)
);

// [testbench/testbench.sv]
`timescale 1ns/100ps
`include "cdr_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module testbench;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rx_frame = 1'b0;
   logic        rx_valid = 1'b0;
   logic        rx_filter_pass = 1'b0;
   logic [4:0]  rx_filter_idx = 5'h00;
   logic [28:0] rx_ident = 29'h0;
   logic        rx_ext = 1'b0, rx_rtr = 1'b0, rx_srr = 1'b0;
   logic [7:0]  reg_rdata_q;
   logic        tx_pending_q, tx_ext_q, tx_abort_q, tx_start, tx_ok, tx_arb_lost, tx_bus_err;
   logic        tx_abort_ack, fe, fr, fs;
   logic [2:0]  tx_buf_q, nxt;
   logic [28:0] tx_ident_q, fid;
   logic [28:0] exp_id[8];
   logic        exp_ext[8];
   logic [4:0]  ffi;
   logic [1:0]  outcome = 2'h0;
   logic [3:0]  lag = 4'hf;
   logic [31:0] seed = 32'h00015abc;
   logic [2:0]  ord[$];
   int          bad_count = 0;
   int          samples_checked = 0;

   cdr_msg_buffers i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .rx_frame(rx_frame), .rx_valid(rx_valid), .rx_filter_pass(rx_filter_pass),
      .rx_filter_idx(rx_filter_idx), .rx_ident(rx_ident), .rx_ext(rx_ext), .rx_rtr(rx_rtr),
      .rx_srr(rx_srr), .tx_pending_q(tx_pending_q), .tx_buf_q(tx_buf_q), .tx_ident_q(tx_ident_q),
      .tx_ext_q(tx_ext_q), .tx_abort_q(tx_abort_q), .tx_start(tx_start), .tx_ok(tx_ok),
      .tx_arb_lost(tx_arb_lost), .tx_bus_err(tx_bus_err), .tx_abort_ack(tx_abort_ack));
   cdr_engine_model i_eng (.sys_clk(sys_clk), .reset(reset), .tx_pending_q(tx_pending_q),
      .tx_abort_q(tx_abort_q), .outcome(outcome), .lag(lag), .tx_start(tx_start), .tx_ok(tx_ok),
      .tx_arb_lost(tx_arb_lost), .tx_bus_err(tx_bus_err), .tx_abort_ack(tx_abort_ack));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Identifier bytes in register order; standard frames give zero extended bytes
   function automatic logic [31:0] id_regs(input logic [28:0] id, input logic e, input logic s);
      if (e)
         return {id[28:21], id[20:18], s, 2'h2, id[17:16], id[15:0]};
      return {id[10:3], id[2:0], 5'h00, 16'h0000};
   endfunction
   task automatic end_of_test();
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic ck(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      `CHK(reg_rdata_q, e)
   endtask
   task automatic newf();
      logic [31:0] x;
      x = rnd();
      {fe, fr, fs, ffi} = {x[0], x[1], x[2], 1'b0, x[6:3]};
      x = rnd();
      fid = fe ? x[28:0] : {18'h00000, x[10:0]};
   endtask
   task automatic send(input logic v, input logic p);
      @(posedge sys_clk);
      {rx_ident, rx_ext, rx_rtr, rx_srr, rx_filter_idx} <= {fid, fe, fr, fs, ffi};
      {rx_frame, rx_valid, rx_filter_pass} <= {1'b1, v, p};
      @(posedge sys_clk);
      rx_frame <= 1'b0;
   endtask
   task automatic ckrx(input logic [7:0] b, input logic acc);
      logic [31:0] x;
      x = id_regs(fid, fe, fs);
      ck(b, {1'b1, acc, fr, ffi});
      for (int k = 0; k < (fe ? 4 : 2); k++)
         ck(8'(b + 1 + k), x[31 - 8 * k -: 8]);
   endtask
   task automatic set_tx(input logic [2:0] n);
      logic [31:0] x;
      newf();
      x = id_regs(fid, fe, 1'b0);
      {exp_id[n], exp_ext[n]} = {fid, fe};
      for (int k = 0; k < 4; k++)
         wr(8'(8'h11 + 8 * n + k), x[31 - 8 * k -: 8] | (k == 1 ? 8'h14 : 8'h00));
      for (int k = 0; k < 4; k++)
         ck(8'(8'h11 + 8 * n + k), x[31 - 8 * k -: 8]);
   endtask
   // Bounded wait for a taken offer (0) or the end of an attempt (1)
   task automatic wt(input logic s);
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge sys_clk);
         if ((s ? tx_ok | tx_arb_lost | tx_bus_err | tx_abort_ack : tx_start & tx_pending_q) === 1'b1)
            break;
      end
      if (i == 300) begin
         bad_count++;
         end_of_test();
      end
   endtask

   // Every taken offer carries what software wrote; the first three taken must follow the queued priority order
   always @(posedge sys_clk) begin
      if (tx_start && tx_pending_q) begin
         `CHK(tx_ident_q & (exp_ext[tx_buf_q] ? 29'h1fffffff : 29'h7ff), exp_id[tx_buf_q])
         `CHK(tx_ext_q, exp_ext[tx_buf_q])
         if (ord.size() > 0) begin
            nxt = ord.pop_front();
            `CHK(tx_buf_q, nxt)
         end
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      newf();
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      ck(`CDR_SEL_ADDR, `CDR_SEL_RESET);
      send(1'b1, 1'b1);
      wr(8'h11, 8'h5a);
      ck(8'h11, 8'h00);
      wr(`CDR_MODE_ADDR, 8'h01);
      ck(8'h10, 8'h00);
      ck(8'h15, 8'h00);
      wr(`CDR_SEL_ADDR, 8'he3);
      ck(`CDR_SEL_ADDR, 8'he0);
      {fid, fe, fr, fs, ffi} = {29'h1fffffff, 1'b1, 1'b1, 1'b1, 5'h0f};
      send(1'b1, 1'b1);
      ckrx(8'h10, 1'b0);
      newf();
      send(1'b1, 1'b1);
      wr(8'h19, fe ? ~fid[28:21] : ~fid[10:3]);
      wr(8'h18, 8'h9f);
      ckrx(8'h18, 1'b0);
      newf();
      send(1'b0, 1'b1);
      send(1'b1, 1'b0);
      ck(8'h20, 8'h00);
      wr(8'h20, 8'h40);
      send(1'b0, 1'b0);
      ckrx(8'h20, 1'b1);
      newf();
      send(1'b1, 1'b1);
      ck(8'h10, 8'haf);
      wr(8'h10, 8'h00);
      send(1'b1, 1'b1);
      ckrx(8'h10, 1'b0);
      wr(`CDR_MODE_ADDR, 8'h02);
      ck(`CDR_MODE_ADDR, 8'h02);
      for (int n = 3; n < 6; n++)
         set_tx(3'(n));
      ord = '{3'h4, 3'h5, 3'h3};
      wr(8'h38, 8'h09);
      wr(8'h30, 8'h0b);
      wr(8'h28, 8'h09);
      wr(8'h38, 8'h0b);
      ck(8'h38, 8'h09);
      repeat (3) wt(1'b1);
      ck(8'h38, 8'h81);
      ck(8'h30, 8'h83);
      outcome <= 2'h1;
      wr(8'h28, 8'h09);
      wt(1'b1);
      ck(8'h28, 8'h29);
      outcome <= 2'h2;
      wt(1'b1);
      ck(8'h28, 8'h39);
      outcome <= 2'h0;
      wt(1'b1);
      ck(8'h28, 8'hb1);
      wr(8'h28, 8'h09);
      ck(8'h28, 8'h09);
      wt(1'b1);
      wr(8'h38, 8'h09);
      wt(1'b0);
      wr(8'h38, 8'h01);
      wt(1'b1);
      ck(8'h38, 8'h41);
      wr(8'h30, 8'h04);
      {fid, fe, fr, fs, ffi} = {exp_id[4], exp_ext[4], 1'b1, 1'b0, 5'h00};
      send(1'b1, 1'b1);
      wt(1'b1);
      ck(8'h30, 8'h84);
      ck(8'h38, 8'h41);
      end_of_test();
   end
endmodule
